// >>> hw/stream_port_sync.v
`timescale 1ns/100ps
`include "stream_port_map.vh"

module stream_port_sync #(
  parameter LEN_W = 12
) (
  input wire clock,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire link_clk,
  input wire transfer_direction,
  input wire data_enable,
  input wire [2:0] buffer_select_lines,
  input wire [7:0] port_data_byte_in,
  output reg [7:0] port_data_byte_out,
  output wire port_data_byte_oe,
  input wire packet_sync_in,
  output reg packet_sync_out,
  output wire packet_sync_oe,
  output wire data_available,
  output reg tx_byte_valid,
  output reg [7:0] tx_byte,
  output reg [2:0] tx_buffer,
  output reg tx_first,
  output reg tx_last,
  input wire [7:0] rx_cell_ready,
  input wire [7:0] rx_byte,
  input wire rx_last_in,
  output wire rx_pop,
  output wire [2:0] rx_buffer
);

  localparam SW = 15;
  localparam TX_HUNT = 2'b01;
  localparam TX_PKT = 2'b10;
  localparam RX_EMPTY = 2'b01;
  localparam RX_FULL = 2'b10;

  // ==========================================================
  // Buffer choice: external select or configured buffer
  function [2:0] pick_buf;
    input multi;
    input [2:0] ext_sel;
    input [2:0] cfg_sel;
    begin
      pick_buf = multi ? ext_sel : cfg_sel;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  wire [SW-1:0] pin_raw;
  reg [SW-1:0] pin_s1_reg;
  reg [SW-1:0] pin_s2_reg;
  reg lclk_prev_reg;

  assign pin_raw = {link_clk, data_enable, transfer_direction, packet_sync_in,
                    buffer_select_lines, port_data_byte_in};

  // Two flops per pin bit
  genvar g;
  generate
    for (g = 0; g < SW; g = g + 1) begin : sync_bit
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          pin_s1_reg[g] <= 1'b0;
          pin_s2_reg[g] <= 1'b0;
        end else begin
          pin_s1_reg[g] <= pin_raw[g];
          pin_s2_reg[g] <= pin_s1_reg[g];
        end
      end
    end
  endgenerate

  // Link clock edge finder
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lclk_prev_reg <= 1'b0;
    end else begin
      lclk_prev_reg <= pin_s2_reg[14];
    end
  end

  wire link_edge = pin_s2_reg[14] & ~lclk_prev_reg;
  wire en_s = pin_s2_reg[13];
  wire dir_rx = pin_s2_reg[12]; // High selects receive
  wire sync_s = pin_s2_reg[11];
  wire [2:0] sel_s = pin_s2_reg[10:8];
  wire [7:0] data_s = pin_s2_reg[7:0];

  // ==========================================================
  // Configuration registers
  reg multi_reg;
  reg [1:0] mode_reg;
  reg tx_en_reg;
  reg [2:0] tx_cfg_reg;
  reg [2:0] rx_cfg_reg;
  reg [2:0] len_idx_reg;
  reg [1:0] mode_prev_reg;
  reg [LEN_W-1:0] len_prev_reg;
  reg dir_prev_reg;
  reg tx_en_prev_reg;
  wire [1:0] wr_mode = reg_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire len_wr = reg_wr && (reg_addr == `OFS_LEN_DATA);

  // Register writes
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      multi_reg <= `RST_MULTI;
      mode_reg <= `RST_MODE;
      tx_en_reg <= `RST_TX_EN;
      tx_cfg_reg <= `RST_BUF;
      rx_cfg_reg <= `RST_BUF;
      len_idx_reg <= `RST_BUF;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_CTRL: begin
          multi_reg <= reg_wdata[`CTRL_MULTI_BIT];
          if (wr_mode != `SYNC_BAD) begin
            mode_reg <= wr_mode;
          end
          tx_en_reg <= reg_wdata[`CTRL_TX_EN_BIT];
        end
        `OFS_BUFSEL: begin
          tx_cfg_reg <= reg_wdata[`BSEL_TX_HI:`BSEL_TX_LO];
          rx_cfg_reg <= reg_wdata[`BSEL_RX_HI:`BSEL_RX_LO];
        end
        `OFS_LEN_INDEX: begin
          len_idx_reg <= reg_wdata[2:0];
        end
        default: begin
          len_idx_reg <= len_idx_reg;
        end
      endcase
    end
  end

  // ==========================================================
  // Active buffer and its stored length
  wire [2:0] tx_sel = pick_buf(multi_reg, sel_s, tx_cfg_reg);
  wire [2:0] rx_sel = pick_buf(multi_reg, sel_s, rx_cfg_reg);
  wire [2:0] act_buf = dir_rx ? rx_sel : tx_sel;
  wire [LEN_W-1:0] cur_len;

  buf_len_mem #(
    .AW(3),
    .DW(LEN_W)
  ) u_len (
    .clock(clock),
    .rst(rst),
    .wr_en(len_wr),
    .wr_addr(len_idx_reg),
    .wr_data(reg_wdata[LEN_W-1:0]),
    .rd_addr(act_buf),
    .rd_data(cur_len)
  );

  // ==========================================================
  // Packet state
  reg [LEN_W-1:0] cnt_reg;
  reg [LEN_W-1:0] cnt_next;
  reg [1:0] tx_st_reg;
  reg [1:0] tx_st_next;
  reg [1:0] rx_st_reg;
  reg [1:0] rx_st_next;
  reg cur_first_reg;
  reg cur_last_reg;
  reg first_next;
  reg last_next;
  reg [7:0] out_next;
  reg sync_next;
  reg tx_take;
  reg tx_start;
  reg tx_end;
  reg rx_load;

  wire [LEN_W:0] cnt_inc = {1'b0, cnt_reg} + 1'b1;
  wire cnt_hit = (cnt_inc >= {1'b0, cur_len});
  wire one_hit = ({{LEN_W{1'b0}}, 1'b1} >= {1'b0, cur_len});
  wire restart = (mode_reg != mode_prev_reg) || (cur_len != len_prev_reg)
                 || (dir_rx != dir_prev_reg) || (tx_en_reg != tx_en_prev_reg);
  wire tx_edge = link_edge & ~dir_rx & en_s & tx_en_reg;
  wire rx_edge = link_edge & dir_rx & en_s;
  wire sel_ready = rx_cell_ready[rx_sel];
  wire [1:0] hunt_state = (mode_reg == `SYNC_B) ? TX_HUNT : TX_PKT;

  // Next-state for both directions
  always @* begin
    cnt_next = cnt_reg;
    tx_st_next = tx_st_reg;
    rx_st_next = rx_st_reg;
    first_next = cur_first_reg;
    last_next = cur_last_reg;
    out_next = port_data_byte_out;
    tx_take = 1'b0;
    tx_start = 1'b0;
    tx_end = 1'b0;
    rx_load = 1'b0;
    if (restart) begin
      cnt_next = {LEN_W{1'b0}};
      tx_st_next = hunt_state;
    end else if (tx_edge) begin
      case (mode_reg)
        `SYNC_B: begin
          if (sync_s) begin
            tx_take = 1'b1;
            tx_start = 1'b1;
            tx_end = one_hit;
            cnt_next = one_hit ? {LEN_W{1'b0}} : {{(LEN_W-1){1'b0}}, 1'b1};
            tx_st_next = one_hit ? TX_HUNT : TX_PKT;
          end else if (tx_st_reg == TX_PKT) begin
            tx_take = 1'b1;
            tx_end = cnt_hit;
            cnt_next = cnt_hit ? {LEN_W{1'b0}} : cnt_inc[LEN_W-1:0];
            tx_st_next = cnt_hit ? TX_HUNT : TX_PKT;
          end
        end
        `SYNC_C: begin
          tx_take = 1'b1;
          tx_start = (cnt_reg == {LEN_W{1'b0}});
          tx_end = sync_s;
          cnt_next = sync_s ? {LEN_W{1'b0}} : {{(LEN_W-1){1'b0}}, 1'b1};
        end
        default: begin
          tx_take = 1'b1;
          tx_start = (cnt_reg == {LEN_W{1'b0}});
          tx_end = cnt_hit;
          cnt_next = cnt_hit ? {LEN_W{1'b0}} : cnt_inc[LEN_W-1:0];
        end
      endcase
    end else if (dir_rx) begin
      case (rx_st_reg)
        RX_EMPTY: begin
          if (sel_ready) begin
            rx_load = 1'b1;
          end
        end
        RX_FULL: begin
          if (rx_edge) begin
            rx_load = sel_ready;
            rx_st_next = sel_ready ? RX_FULL : RX_EMPTY;
          end
        end
        default: begin
          rx_st_next = RX_EMPTY;
        end
      endcase
      if (rx_load) begin
        rx_st_next = RX_FULL;
        out_next = rx_byte;
        first_next = (cnt_reg == {LEN_W{1'b0}});
        last_next = (mode_reg == `SYNC_C) ? rx_last_in : cnt_hit;
        if (mode_reg == `SYNC_C) begin
          cnt_next = rx_last_in ? {LEN_W{1'b0}} : {{(LEN_W-1){1'b0}}, 1'b1};
        end else begin
          cnt_next = cnt_hit ? {LEN_W{1'b0}} : cnt_inc[LEN_W-1:0];
        end
      end
    end else begin
      rx_st_next = RX_EMPTY;
    end
    case (mode_reg)
      `SYNC_B: sync_next = (rx_st_next == RX_FULL) & first_next;
      `SYNC_C: sync_next = (rx_st_next == RX_FULL) & last_next;
      default: sync_next = 1'b0;
    endcase
  end

  // ==========================================================
  // State registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= {LEN_W{1'b0}};
      tx_st_reg <= TX_PKT;
      rx_st_reg <= RX_EMPTY;
      cur_first_reg <= 1'b0;
      cur_last_reg <= 1'b0;
      port_data_byte_out <= 8'h00;
      packet_sync_out <= 1'b0;
      mode_prev_reg <= `RST_MODE;
      len_prev_reg <= `RST_LEN;
      dir_prev_reg <= 1'b0;
      tx_en_prev_reg <= `RST_TX_EN;
    end else begin
      cnt_reg <= cnt_next;
      tx_st_reg <= tx_st_next;
      rx_st_reg <= rx_st_next;
      cur_first_reg <= first_next;
      cur_last_reg <= last_next;
      port_data_byte_out <= out_next;
      packet_sync_out <= sync_next;
      mode_prev_reg <= mode_reg;
      len_prev_reg <= cur_len;
      dir_prev_reg <= dir_rx;
      tx_en_prev_reg <= tx_en_reg;
    end
  end

  // ==========================================================
  // Transmit byte hand-off to the buffer side
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_byte_valid <= 1'b0;
      tx_byte <= 8'h00;
      tx_buffer <= `RST_BUF;
      tx_first <= 1'b0;
      tx_last <= 1'b0;
    end else begin
      tx_byte_valid <= tx_take;
      if (tx_take) begin
        tx_byte <= data_s;
        tx_buffer <= tx_sel;
        tx_first <= tx_start;
        tx_last <= tx_end;
      end
    end
  end

  // ==========================================================
  // Receive pins
  wire rx_full = (rx_st_reg == RX_FULL);
  assign data_available = rx_full & dir_rx & ~(cur_last_reg & ~sel_ready);
  assign port_data_byte_oe = dir_rx;
  assign packet_sync_oe = dir_rx & (mode_reg != `SYNC_A);
  assign rx_pop = rx_load;
  assign rx_buffer = rx_sel;

  // ==========================================================
  // Register read data, one cycle after the strobe
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0000_0000;
      case (reg_addr)
        `OFS_CTRL: begin
          reg_rdata[`CTRL_MULTI_BIT] <= multi_reg;
          reg_rdata[`CTRL_MODE_HI:`CTRL_MODE_LO] <= mode_reg;
          reg_rdata[`CTRL_TX_EN_BIT] <= tx_en_reg;
        end
        `OFS_BUFSEL: begin
          reg_rdata[`BSEL_TX_HI:`BSEL_TX_LO] <= tx_cfg_reg;
          reg_rdata[`BSEL_RX_HI:`BSEL_RX_LO] <= rx_cfg_reg;
        end
        `OFS_LEN_INDEX: begin
          reg_rdata[2:0] <= len_idx_reg;
        end
        `OFS_STATUS: begin
          reg_rdata[`STAT_CNT_LO+LEN_W-1:`STAT_CNT_LO] <= cnt_reg;
          reg_rdata[`STAT_DIR_BIT] <= dir_rx;
          reg_rdata[`STAT_HUNT_BIT] <= (tx_st_reg == TX_HUNT);
          reg_rdata[`STAT_FULL_BIT] <= rx_full;
          reg_rdata[`STAT_AVAIL_BIT] <= data_available;
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// >>> hw/stream_port_map.vh
`ifndef STREAM_PORT_MAP_VH
`define STREAM_PORT_MAP_VH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_BUFSEL 8'h04
`define OFS_LEN_INDEX 8'h08
`define OFS_LEN_DATA 8'h0c
`define OFS_STATUS 8'h10

// ==========================================================
// Control register fields
`define CTRL_MULTI_BIT 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_TX_EN_BIT 3

// Buffer select register fields
`define BSEL_TX_LO 0
`define BSEL_TX_HI 2
`define BSEL_RX_LO 4
`define BSEL_RX_HI 6

// Status register fields
`define STAT_CNT_LO 0
`define STAT_DIR_BIT 16
`define STAT_HUNT_BIT 17
`define STAT_FULL_BIT 18
`define STAT_AVAIL_BIT 19

// ==========================================================
// Sync mode codes
`define SYNC_A 2'h0
`define SYNC_B 2'h1
`define SYNC_C 2'h2
`define SYNC_BAD 2'h3

// ==========================================================
// Reset values
`define RST_MULTI 1'h0
`define RST_MODE 2'h0
`define RST_TX_EN 1'h0
`define RST_BUF 3'h0
`define RST_LEN 12'h0bc

`endif

// >>> hw/buf_len_mem.v
`timescale 1ns/100ps
`include "stream_port_map.vh"

// Per-buffer packet length store, registered read
module buf_len_mem #(
  parameter AW = 3,
  parameter DW = 12
) (
  input wire clock,
  input wire rst,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ==========================================================
  // Storage, each entry resets to the default length
  genvar g;
  generate
    for (g = 0; g < (1 << AW); g = g + 1) begin : entry
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          mem[g] <= `RST_LEN;
        end else if (wr_en && (wr_addr == g)) begin
          mem[g] <= wr_data;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Registered read port
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= `RST_LEN;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// >>> bench/stream_port_sync_chk.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker for the stream port
module stream_port_sync_chk #(
  parameter LEN_W = 12
) (
  input logic clock,
  input logic rst,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  input logic data_enable,
  input logic [7:0] port_data_byte_out,
  input logic port_data_byte_oe,
  input logic packet_sync_out,
  input logic packet_sync_oe,
  input logic data_available,
  input logic tx_byte_valid,
  input logic tx_last,
  input logic [7:0] rx_cell_ready,
  input logic [7:0] rx_byte,
  input logic rx_pop,
  input logic [2:0] rx_buffer
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================================
  // Register and transmit side
  a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_tx_spacing: assert property (tx_byte_valid |=> (!tx_byte_valid)[*4])
    else $error("transmit bytes too close");
  a_tx_needs_en: assert property ((!data_enable)[*8] |-> !tx_byte_valid)
    else $error("byte taken with enable low");
  a_tx_not_rx: assert property (port_data_byte_oe |-> !tx_byte_valid)
    else $error("byte taken while receiving");

  // ==========================================================
  // Receive side
  a_sync_oe_rx: assert property (packet_sync_oe |-> port_data_byte_oe)
    else $error("sync driven outside receive");
  a_rx_hold: assert property ((!data_enable)[*4] ##0 (port_data_byte_oe && data_available &&
    $past(data_available)) |=> $stable(port_data_byte_out))
    else $error("receive byte changed while paused");
  a_pop_data: assert property (rx_pop |=> port_data_byte_out == $past(rx_byte))
    else $error("popped byte not on the bus");
  a_pop_ready: assert property (rx_pop |-> rx_cell_ready[rx_buffer])
    else $error("pop without a ready cell");
  a_pop_spacing: assert property (rx_pop |=> (!rx_pop)[*4])
    else $error("receive pops too close");

  // Main scenarios reached
  c_tx_last: cover property (tx_byte_valid && tx_last);
  c_rx_pop: cover property (rx_pop);
  c_rx_sync: cover property (packet_sync_out && packet_sync_oe);
endmodule

bind stream_port_sync stream_port_sync_chk #(.LEN_W(LEN_W)) u_chk (
  .clock(clock), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_enable(data_enable),
  .port_data_byte_out(port_data_byte_out), .port_data_byte_oe(port_data_byte_oe),
  .packet_sync_out(packet_sync_out), .packet_sync_oe(packet_sync_oe), .data_available(data_available),
  .tx_byte_valid(tx_byte_valid), .tx_last(tx_last), .rx_cell_ready(rx_cell_ready), .rx_byte(rx_byte),
  .rx_pop(rx_pop), .rx_buffer(rx_buffer)
);

// >>> bench/stream_link_partner.sv
`timescale 1ns/100ps
// ==========================================================
// Far-side stream source and sink
module stream_link_partner (
  output logic link_clk,
  output logic transfer_direction,
  output logic data_enable,
  output logic [2:0] buffer_select_lines,
  output logic [7:0] port_data_byte,
  output logic packet_sync
);
  // Quiet link at start
  initial begin
    link_clk = 1'b0;
    transfer_direction = 1'b0;
    data_enable = 1'b0;
    buffer_select_lines = 3'h0;
    port_data_byte = 8'h00;
    packet_sync = 1'b0;
  end

  // One byte slot, pins set up well ahead of the rising link edge
  task automatic xfer(input logic [7:0] d, input logic s, input logic [2:0] a, input logic e);
    port_data_byte <= d;
    packet_sync <= s;
    buffer_select_lines <= a;
    data_enable <= e;
    #213;
    link_clk <= 1'b1;
    #187;
    link_clk <= 1'b0;
  endtask

  // Between frames the clock stands still and released lines invert
  task automatic idle;
    port_data_byte <= ~port_data_byte;
    packet_sync <= ~packet_sync;
    data_enable <= 1'b0;
  endtask

  task automatic set_dir(input logic r);
    transfer_direction <= r;
  endtask
endmodule

// >>> bench/stream_port_sync_tb.sv
`timescale 1ns/100ps
`include "stream_port_map.vh"
// ==========================================================
// Testbench for the stream port
module stream_port_sync_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_fill = 1'b0;
  logic [1:0] rx_head = 2'h0;
  logic [31:0] reg_rdata;
  logic link_clk, dir, en, sync_p, sync_in, sync_out, sync_oe, d_oe, avail, txv, tx_first, tx_last, rx_pop;
  logic [2:0] sel, tx_buffer, rx_buffer;
  logic [7:0] d_p, d_in, d_out, tx_byte, rx_byte, rx_cell_ready;
  logic [12:0] txq[$];
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  stream_link_partner far (.link_clk(link_clk), .transfer_direction(dir), .data_enable(en),
    .buffer_select_lines(sel), .port_data_byte(d_p), .packet_sync(sync_p));

  stream_port_sync dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .transfer_direction(dir), .data_enable(en), .buffer_select_lines(sel), .port_data_byte_in(d_in),
    .port_data_byte_out(d_out), .port_data_byte_oe(d_oe), .packet_sync_in(sync_in),
    .packet_sync_out(sync_out), .packet_sync_oe(sync_oe), .data_available(avail), .tx_byte_valid(txv),
    .tx_byte(tx_byte), .tx_buffer(tx_buffer), .tx_first(tx_first), .tx_last(tx_last),
    .rx_cell_ready(rx_cell_ready), .rx_byte(rx_byte), .rx_last_in(rx_head == 2'h2), .rx_pop(rx_pop),
    .rx_buffer(rx_buffer));

  // Shared pins resolved from both drivers
  assign d_in = d_oe ? d_out : d_p;
  assign sync_in = sync_oe ? sync_out : sync_p;
  // Receive buffer 3 holds one packet of three bytes
  assign rx_byte = 8'ha0 + {6'h0, rx_head};
  assign rx_cell_ready = {4'h0, rx_fill && (rx_head < 2'h3), 3'h0};

  // Pop tracking, transmit capture and hang guard
  always @(posedge clock) begin
    if (rx_pop) begin
      rx_head <= rx_head + 2'h1;
    end
    if (txv) begin
      txq.push_back({tx_first, tx_last, tx_buffer, tx_byte});
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("register read", exp, reg_rdata);
  endtask

  // Close a frame, then let the pipeline land for eight clocks
  task automatic settle;
    far.idle();
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic tx_exp(input logic [12:0] e);
    if (txq.size() == 0) begin
      chk("tx record count", 32'h1, 32'h0);
    end else begin
      chk("tx record", {19'h0, e}, {19'h0, txq.pop_front()});
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_BUFSEL, 32'h0);
    rd(8'h14, 32'h0);
    wr(`OFS_CTRL, 32'h6);
    rd(`OFS_CTRL, 32'h0);
  endtask

  task automatic t_mode_a;
    wr(`OFS_LEN_INDEX, 32'h2);
    wr(`OFS_LEN_DATA, 32'h3);
    wr(`OFS_BUFSEL, 32'h2);
    wr(`OFS_CTRL, 32'h8);
    far.xfer(8'h11, 1'b1, 3'h5, 1'b1);
    far.xfer(8'h22, 1'b0, 3'h5, 1'b1);
    far.xfer(8'h99, 1'b1, 3'h5, 1'b0);
    far.xfer(8'h33, 1'b0, 3'h5, 1'b1);
    far.xfer(8'h44, 1'b0, 3'h5, 1'b1);
    settle();
    tx_exp({2'b10, 3'h2, 8'h11});
    tx_exp({2'b00, 3'h2, 8'h22});
    tx_exp({2'b01, 3'h2, 8'h33});
    tx_exp({2'b10, 3'h2, 8'h44});
    chk("tx leftovers", 32'h0, txq.size());
  endtask

  task automatic t_mode_b;
    wr(`OFS_CTRL, 32'ha);
    rd(`OFS_STATUS, 32'h0002_0000);
    far.xfer(8'h55, 1'b0, 3'h0, 1'b1);
    far.xfer(8'h66, 1'b1, 3'h0, 1'b1);
    far.xfer(8'h77, 1'b0, 3'h0, 1'b1);
    far.xfer(8'h88, 1'b0, 3'h0, 1'b1);
    far.xfer(8'h5a, 1'b0, 3'h0, 1'b1);
    far.xfer(8'h69, 1'b1, 3'h0, 1'b1);
    settle();
    tx_exp({2'b10, 3'h2, 8'h66});
    tx_exp({2'b00, 3'h2, 8'h77});
    tx_exp({2'b01, 3'h2, 8'h88});
    tx_exp({2'b10, 3'h2, 8'h69});
  endtask

  task automatic t_mode_c;
    wr(`OFS_CTRL, 32'hd);
    far.xfer(8'hc1, 1'b0, 3'h5, 1'b1);
    far.xfer(8'hc2, 1'b1, 3'h5, 1'b0);
    far.xfer(8'hc3, 1'b1, 3'h5, 1'b1);
    far.xfer(8'hc4, 1'b0, 3'h6, 1'b1);
    far.xfer(8'hc5, 1'b1, 3'h6, 1'b1);
    settle();
    tx_exp({2'b10, 3'h5, 8'hc1});
    tx_exp({2'b01, 3'h5, 8'hc3});
    tx_exp({2'b10, 3'h6, 8'hc4});
    tx_exp({2'b01, 3'h6, 8'hc5});
  endtask

  task automatic t_rx;
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_BUFSEL, 32'h30);
    far.set_dir(1'b1);
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk("sync oe mode A", 32'h0, sync_oe);
    chk("data oe", 32'h1, d_oe);
    chk("rx buffer", 32'h3, rx_buffer);
    chk("avail empty", 32'h0, avail);
    wr(`OFS_CTRL, 32'h4);
    rx_fill <= 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk("sync oe mode C", 32'h1, sync_oe);
    chk("first byte", 32'ha0, d_out);
    chk("avail first", 32'h1, avail);
    repeat (10) @(posedge clock);
    far.xfer(8'h00, 1'b0, 3'h0, 1'b0);
    @(negedge clock);
    chk("held byte", 32'ha0, d_out);
    chk("avail paused", 32'h1, avail);
    far.xfer(8'h00, 1'b0, 3'h0, 1'b1);
    settle();
    chk("second byte", 32'ha1, d_out);
    chk("no sync mid", 32'h0, sync_out);
    far.xfer(8'h00, 1'b0, 3'h0, 1'b1);
    settle();
    chk("last byte", 32'ha2, d_out);
    chk("sync last", 32'h1, sync_out);
    chk("avail last", 32'h0, avail);
    rd(`OFS_STATUS, 32'h0005_0000);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_mode_a();
    t_mode_b();
    t_mode_c();
    t_rx();
    results();
  end
endmodule
